// ### src/demod_ctrl_pkg.sv
package demod_ctrl_pkg;

	// APB register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_THRESH = 8'h04;
	localparam logic [7:0] OFF_SLEEP  = 8'h08;
	localparam logic [7:0] OFF_RXTIME = 8'h0c;
	localparam logic [7:0] OFF_SYMBOL = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_CAL    = 8'h18;

	// Control register, bit 0 first from the bottom
	typedef struct packed {
		logic       duty_cycle;
		logic [1:0] preamble_len;
		logic [2:0] step_idx;
		logic [1:0] decay_rate;
		logic       decay_en;
		logic       tracked_peak_slicing;
		logic       agc_enable;
		logic       freq_correction_enable;
		logic       sync_counting;
		logic       high_tone_is_zero;
		logic       mode_ook;
	} ctrl_s;

	typedef struct packed {
		logic [7:0] fixed_level;
		logic [7:0] off_margin;
		logic [3:0] on_margin_idx;
	} thresh_s;

	localparam logic [14:0] CTRL_RST    = 15'h507c;
	localparam logic [19:0] THRESH_RST  = 20'h3cff7;
	localparam int          SLEEP_W     = 27;
	localparam logic [26:0] SLEEP_MIN   = 27'h0000003;
	localparam logic [26:0] SLEEP_MAX   = 27'h7ff0000;
	localparam logic [26:0] SLEEP_RST   = 27'h0000003;
	localparam logic [26:0] SLEEP_ALWAYS = 27'h0000003;
	localparam logic [26:0] RXTIME_RST  = 27'h00007d0;
	localparam logic [15:0] HALF_SYM_RST = 16'h1964;

	// Timing
	localparam longint CLK_HZ      = 125000000;
	localparam longint LOW_POWER_OSC_HZ    = 1000;
	localparam int     CAL_TOL_PCT = 1;
	localparam logic [19:0] CAL_NOM = 20'(CLK_HZ / LOW_POWER_OSC_HZ);
	localparam logic [19:0] CAL_TOL = 20'(CLK_HZ / LOW_POWER_OSC_HZ * CAL_TOL_PCT / 100);

	localparam logic [7:0] BYTE_BITS = 8'h08;
	localparam logic [7:0] SAR_MSB   = 8'h80;
	localparam logic [2:0] SAR_TOP   = 3'h7;

	typedef enum logic [1:0] {PWR_UP, CAL, SLEEP, RX} pwr_e;

endpackage : demod_ctrl_pkg

// ### src/demod_ctrl.sv
`timescale 1ns/1ps
module demod_ctrl
	import demod_ctrl_pkg::*;
#(
	parameter int CAL_WAKES = 16
)(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        rssi_cmp,
	input  wire logic        fsk_tone,
	input  wire logic        low_power_osc_tick,
	output logic [7:0]       sar_dac,
	output logic             demod_data,
	output logic             demod_enable,
	output logic             sym_clk,
	output logic             preamble_valid,
	output logic             rx_active,
	output logic             freq_correction_enable,
	output logic             agc_enable,
	output logic [5:0]       low_power_osc_trim
);

	if (CAL_WAKES < 1 || CAL_WAKES > 255)
		$error("CAL_WAKES out of range");

	////////////////////////////////////////////////////////////////////////
	// Registers and APB

	ctrl_s       ctrl;
	thresh_s     thr;
	logic [26:0] sleep_ms;
	logic [26:0] rx_ms;
	logic [15:0] half_sym;
	logic [7:0]  rssi_code;
	logic [7:0]  peak;
	logic        cal_done;
	logic [19:0] cal_meas;
	pwr_e        pwr;

	wire        access   = psel && penable && !pready;
	wire        wr       = psel && penable && pready && pwrite;
	wire        hit_ctrl = paddr == OFF_CTRL;
	wire        hit_thr  = paddr == OFF_THRESH;
	wire        hit_slp  = paddr == OFF_SLEEP;
	wire        hit_rx   = paddr == OFF_RXTIME;
	wire        hit_sym  = paddr == OFF_SYMBOL;
	wire        hit_st   = paddr == OFF_STATUS;
	wire        hit_cal  = paddr == OFF_CAL;
	wire        mapped   = hit_ctrl | hit_thr | hit_slp | hit_rx | hit_sym | hit_st | hit_cal;
	// Out-of-range sleep requests are clamped so the timer never runs shorter than the minimum
	wire [26:0] wr_sleep = (pwdata[26:0] < SLEEP_MIN) ? SLEEP_MIN :
		(pwdata[26:0] > SLEEP_MAX) ? SLEEP_MAX : pwdata[26:0];
	wire [31:0] status   = {9'h000, pwr, cal_done, preamble_valid, demod_data, rx_active,
		demod_enable, peak, rssi_code};
	wire [31:0] rd_mux   = hit_ctrl ? {17'h00000, ctrl} :
		hit_thr ? {12'h000, thr} :
		hit_slp ? {5'h00, sleep_ms} :
		hit_rx  ? {5'h00, rx_ms} :
		hit_sym ? {16'h0000, half_sym} :
		hit_st  ? status :
		hit_cal ? {6'h00, low_power_osc_trim, cal_meas} : 32'h00000000;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else if (ce)
		begin
			pready  <= access;
			pslverr <= access && !mapped;
			prdata  <= (access && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl     <= CTRL_RST;
			thr      <= THRESH_RST;
			sleep_ms <= SLEEP_RST;
			rx_ms    <= RXTIME_RST;
			half_sym <= HALF_SYM_RST;
		end
		else if (ce && wr)
		begin
			if (hit_ctrl) ctrl <= pwdata[14:0];
			if (hit_thr) thr <= pwdata[19:0];
			if (hit_slp) sleep_ms <= wr_sleep;
			if (hit_rx) rx_ms <= pwdata[26:0];
			if (hit_sym && pwdata[15:0] != 16'h0000) half_sym <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			freq_correction_enable <= 1'b1;
			agc_enable             <= 1'b1;
		end
		else if (ce)
		begin
			freq_correction_enable <= ctrl.freq_correction_enable;
			agc_enable             <= ctrl.agc_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// SAR converter, one bit decided per clock, free running

	logic [2:0] sar_bit;
	logic       code_valid;
	// Trial bit walks down from the top, so the mask is the bit under test this cycle
	wire  [7:0] sar_mask  = SAR_MSB >> (SAR_TOP - sar_bit);
	wire  [7:0] sar_keep  = rssi_cmp ? sar_dac : (sar_dac & ~sar_mask);
	wire        sar_last  = sar_bit == 3'h0;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sar_dac    <= SAR_MSB;
			sar_bit    <= SAR_TOP;
			rssi_code  <= 8'h00;
			code_valid <= 1'b0;
		end
		else if (ce)
		begin
			code_valid <= sar_last;
			if (sar_last)
			begin
				rssi_code <= sar_keep;
				sar_dac   <= SAR_MSB;
				sar_bit   <= SAR_TOP;
			end
			else
			begin
				sar_dac <= sar_keep | (sar_mask >> 1);
				sar_bit <= sar_bit - 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sleep timer, calibration and power states

	logic [26:0] ms_cnt;
	logic [7:0]  wake_cnt;
	logic        cal_armed;
	logic        cal_run;
	logic        after_pup;
	logic [19:0] cal_cnt;
	logic        wake;

	wire [26:0] sleep_lim = ctrl.duty_cycle ? sleep_ms : SLEEP_ALWAYS;
	wire        cal_end   = cal_run && cal_armed && low_power_osc_tick;
	wire        osc_slow  = cal_cnt > CAL_NOM + CAL_TOL;
	wire        osc_fast  = cal_cnt < CAL_NOM - CAL_TOL;
	wire        sleep_end = pwr == SLEEP && low_power_osc_tick && ms_cnt + 27'h1 >= sleep_lim;
	wire        rx_end    = pwr == RX && ctrl.duty_cycle && low_power_osc_tick && ms_cnt + 27'h1 >= rx_ms;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cal_armed          <= 1'b0;
			cal_cnt            <= 20'h00000;
			cal_meas           <= 20'h00000;
			cal_done           <= 1'b0;
			low_power_osc_trim <= 6'h20;
		end
		else if (ce)
		begin
			if (!cal_run)
				cal_armed <= 1'b0;
			else if (low_power_osc_tick)
			begin
				cal_armed <= !cal_armed;
				cal_cnt   <= 20'h00000;
			end
			else if (cal_cnt != 20'hfffff)
				cal_cnt <= cal_cnt + 20'h1;
			if (cal_end)
			begin
				cal_meas <= cal_cnt;
				cal_done <= 1'b1;
				// A slow oscillator shows too many reference cycles per tick
				if (osc_slow && low_power_osc_trim != 6'h3f)
					low_power_osc_trim <= low_power_osc_trim + 6'h1;
				else if (osc_fast && low_power_osc_trim != 6'h00)
					low_power_osc_trim <= low_power_osc_trim - 6'h1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pwr       <= PWR_UP;
			ms_cnt    <= 27'h0;
			wake_cnt  <= 8'h00;
			after_pup <= 1'b1;
			wake      <= 1'b0;
			rx_active <= 1'b0;
		end
		else if (ce)
		begin
			wake <= 1'b0;
			case (pwr)
				PWR_UP:
					pwr <= CAL;
				CAL:
					if (cal_end)
					begin
						pwr       <= after_pup ? SLEEP : RX;
						wake      <= !after_pup;
						rx_active <= !after_pup;
						after_pup <= 1'b0;
						ms_cnt    <= 27'h0;
					end
				SLEEP:
					if (sleep_end)
					begin
						ms_cnt   <= 27'h0;
						wake_cnt <= (wake_cnt + 8'h1 >= 8'(CAL_WAKES)) ? 8'h00 : wake_cnt + 8'h1;
						if (wake_cnt == 8'h00 && ctrl.duty_cycle)
							pwr <= CAL;
						else
						begin
							pwr       <= RX;
							wake      <= 1'b1;
							rx_active <= 1'b1;
						end
					end
					else if (low_power_osc_tick)
						ms_cnt <= ms_cnt + 27'h1;
				RX:
					if (rx_end)
					begin
						pwr       <= SLEEP;
						ms_cnt    <= 27'h0;
						rx_active <= 1'b0;
					end
					else if (low_power_osc_tick && ctrl.duty_cycle)
						ms_cnt <= ms_cnt + 27'h1;
				default:
					pwr <= PWR_UP;
			endcase
		end
	end

	assign cal_run = pwr == CAL;

	////////////////////////////////////////////////////////////////////////
	// FSK gating, OOK slicing, peak tracking

	logic [7:0] floor_lvl;
	logic [7:0] on_ref;
	logic       raw_bit;
	logic       hs_tick;
	logic [3:0] decay_div;

	function automatic logic [7:0] on_margin(input logic [3:0] idx);
		case (idx)
			4'h0: on_margin = 8'h00;
			4'h1: on_margin = 8'h03;
			4'h2: on_margin = 8'h06;
			4'h3: on_margin = 8'h09;
			4'h4: on_margin = 8'h0c;
			4'h5: on_margin = 8'h0f;
			4'h6: on_margin = 8'h12;
			4'h7: on_margin = 8'h15;
			4'h8: on_margin = 8'h18;
			4'h9: on_margin = 8'h1b;
			4'ha: on_margin = 8'h1e;
			4'hb: on_margin = 8'h24;
			4'hc: on_margin = 8'h2a;
			4'hd: on_margin = 8'h36;
			4'he: on_margin = 8'h42;
			default: on_margin = 8'h5a;
		endcase
	endfunction : on_margin

	function automatic logic [7:0] drop_step(input logic [2:0] idx);
		case (idx)
			3'h0: drop_step = 8'h01;
			3'h1: drop_step = 8'h02;
			3'h2: drop_step = 8'h03;
			3'h3: drop_step = 8'h05;
			3'h4: drop_step = 8'h06;
			3'h5: drop_step = 8'h09;
			3'h6: drop_step = 8'h0c;
			default: drop_step = 8'h0f;
		endcase
	endfunction : drop_step

	wire [8:0] on_level  = {1'b0, floor_lvl} + {1'b0, on_margin(thr.on_margin_idx)};
	wire       fsk_rise  = {1'b0, rssi_code} > on_level;
	wire       fsk_fall  = {1'b0, on_ref} > {1'b0, rssi_code} + {1'b0, thr.off_margin};
	wire [3:0] decay_top = 4'h8 >> ctrl.decay_rate;
	wire       decay_now = hs_tick && decay_div + 4'h1 >= decay_top;
	wire [7:0] step      = drop_step(ctrl.step_idx);
	wire [7:0] ook_thr   = ctrl.tracked_peak_slicing ? {1'b0, peak[7:1]} : thr.fixed_level;
	wire       fsk_bit   = demod_enable && (fsk_tone ^ ctrl.high_tone_is_zero);
	wire       ook_bit   = rssi_code > ook_thr;

	assign raw_bit = ctrl.mode_ook ? ook_bit : fsk_bit;

	always_ff @(posedge clk)
	begin
		if (rst || (ce && wake))
		begin
			demod_enable <= 1'b0;
			floor_lvl    <= 8'hff;
			on_ref       <= 8'h00;
			peak         <= 8'h00;
			decay_div    <= 4'h0;
		end
		else if (ce)
		begin
			if (hs_tick)
				decay_div <= decay_now ? 4'h0 : decay_div + 4'h1;
			if (code_valid && !ctrl.mode_ook)
			begin
				// Only the strength code decides; tone activity never gates the demodulator
				if (!demod_enable)
				begin
					floor_lvl <= (rssi_code < floor_lvl) ? rssi_code : floor_lvl;
					if (fsk_rise)
					begin
						demod_enable <= 1'b1;
						on_ref       <= rssi_code;
					end
				end
				else if (fsk_fall)
				begin
					demod_enable <= 1'b0;
					floor_lvl    <= rssi_code;
				end
				else if (rssi_code > on_ref)
					on_ref <= rssi_code;
			end
			if (code_valid && rssi_code > peak)
				peak <= rssi_code;
			else if (decay_now && ctrl.decay_en)
				peak <= (peak > step) ? peak - step : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Symbol clock recovery, data output, preamble

	logic [15:0] hs_cnt;
	logic        last_raw;
	logic        last_bit;
	logic [5:0]  pre_cnt;

	// Tracing realigns on every data edge; counting free-runs and is immune to edge jitter
	wire       retrace   = !ctrl.sync_counting && raw_bit != last_raw;
	wire       sample    = hs_tick && sym_clk;
	wire [5:0] pre_need  = 6'({2'b00, ctrl.preamble_len} + 4'h1) * 6'(BYTE_BITS);

	assign hs_tick = hs_cnt + 16'h1 >= half_sym;

	always_ff @(posedge clk)
	begin
		if (rst || (ce && wake))
		begin
			hs_cnt         <= 16'h0000;
			sym_clk        <= 1'b0;
			last_raw       <= 1'b0;
			last_bit       <= 1'b0;
			pre_cnt        <= 6'h00;
			preamble_valid <= 1'b0;
			demod_data     <= 1'b0;
		end
		else if (ce)
		begin
			last_raw <= raw_bit;
			if (retrace)
			begin
				hs_cnt  <= 16'h0000;
				sym_clk <= 1'b0;
			end
			else if (hs_tick)
			begin
				hs_cnt  <= 16'h0000;
				sym_clk <= !sym_clk;
			end
			else
				hs_cnt <= hs_cnt + 16'h1;
			if (!rx_active)
				demod_data <= 1'b0;
			else if (sample)
				demod_data <= raw_bit;
			if (sample)
			begin
				last_bit <= raw_bit;
				if (raw_bit != last_bit && pre_cnt != 6'h3f)
					pre_cnt <= pre_cnt + 6'h1;
				else if (raw_bit == last_bit)
					pre_cnt <= 6'h00;
				preamble_valid <= raw_bit != last_bit && pre_cnt + 6'h1 >= pre_need;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_sleeping;
		ce && pwr == SLEEP;
	endsequence
	sequence s_rx_entered;
		ce && wake ##1 rx_active;
	endsequence

	property p_data_zero;
		ce && !rx_active |=> !demod_data;
	endproperty
	a_data_zero: assert property (p_data_zero) else $error("Data not zero outside receive");

	property p_wake_clear;
		s_sleeping ##1 s_rx_entered |-> !demod_enable && peak == 8'h00;
	endproperty
	a_wake_clear: assert property (p_wake_clear) else $error("Demod state survived wake");

	property p_peak_load;
		ce && code_valid && rssi_code > peak |=> peak == $past(rssi_code);
	endproperty
	a_peak_load: assert property (p_peak_load) else $error("Peak missed larger sample");

	property p_peak_hold;
		ce && !ctrl.decay_en && !wake && !(code_valid && rssi_code > peak) |=> $stable(peak);
	endproperty
	a_peak_hold: assert property (p_peak_hold) else $error("Peak moved with decay off");

	property p_sar_period;
		ce && code_valid |=> !code_valid;
	endproperty
	a_sar_period: assert property (p_sar_period) else $error("Code valid held too long");

	property p_sar_start;
		ce && sar_last |=> sar_dac == SAR_MSB;
	endproperty
	a_sar_start: assert property (p_sar_start) else $error("Conversion did not restart");

	property p_demod_on;
		ce && code_valid && !ctrl.mode_ook && !demod_enable && fsk_rise && !wake |=> demod_enable;
	endproperty
	a_demod_on: assert property (p_demod_on) else $error("Demod not enabled at rise");

	property p_demod_hyst;
		ce && demod_enable && !code_valid && !wake |=> demod_enable;
	endproperty
	a_demod_hyst: assert property (p_demod_hyst) else $error("Demod dropped without sample");

	property p_sleep_floor;
		ce && pwr == SLEEP && low_power_osc_tick && ms_cnt + 27'h1 < sleep_lim |=> pwr == SLEEP;
	endproperty
	a_sleep_floor: assert property (p_sleep_floor) else $error("Woke before sleep period");

	property p_afc_follow;
		ce ##1 ce |-> freq_correction_enable == $past(ctrl.freq_correction_enable);
	endproperty
	a_afc_follow: assert property (p_afc_follow) else $error("Correction enable lags");

endmodule : demod_ctrl

// ### tb/rf_front_model.sv
`timescale 1ns/1ps
// Analog side of the block: signal-strength comparator and slow oscillator
module rf_front_model #(
	parameter int TICK_CYCLES = 20
)(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] level,
	input  wire logic [7:0] sar_dac,
	output logic            rssi_cmp,
	output logic            low_power_osc_tick
);
	int cnt;

	// Combinational, so it answers the trial code of the same cycle
	assign rssi_cmp = (level >= sar_dac);

	// Short period keeps calibration and sleep runs brief
	always_ff @(posedge clk)
	begin
		if (rst || cnt == TICK_CYCLES - 1)
			cnt <= 0;
		else
			cnt <= cnt + 1;
		low_power_osc_tick <= (cnt == TICK_CYCLES - 1);
	end
endmodule : rf_front_model

// ### tb/rssi_gated_demod_control_test.sv
`timescale 1ns/1ps
module rssi_gated_demod_control_test;
	import demod_ctrl_pkg::*;

	logic        clk;
	logic        rst;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        rssi_cmp;
	logic        fsk_tone;
	logic        low_power_osc_tick;
	logic [7:0]  sar_dac;
	logic        demod_data;
	logic        demod_enable;
	logic        sym_clk;
	logic        preamble_valid;
	logic        rx_active;
	logic        afc_en;
	logic        agc_en;
	logic [5:0]  trim;
	logic [7:0]  level;
	logic [31:0] rd;
	logic        err;
	logic [31:0] regs [5];
	int          num_errors;
	int          n_compared;
	int          seed;
	int          per;
	int          p0;
	int          drop;
	int          steps [8] = '{1, 2, 3, 5, 6, 9, 12, 15};

	demod_ctrl #(.CAL_WAKES(1)) u_dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.rssi_cmp(rssi_cmp), .fsk_tone(fsk_tone), .low_power_osc_tick(low_power_osc_tick), .sar_dac(sar_dac),
		.demod_data(demod_data), .demod_enable(demod_enable), .sym_clk(sym_clk),
		.preamble_valid(preamble_valid), .rx_active(rx_active), .freq_correction_enable(afc_en),
		.agc_enable(agc_en), .low_power_osc_trim(trim));

	rf_front_model u_front (.clk(clk), .rst(rst), .level(level), .sar_dac(sar_dac), .rssi_cmp(rssi_cmp),
		.low_power_osc_tick(low_power_osc_tick));

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Holds the request until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		check(32'(err), 32'(a > OFF_CAL));
		case (a)
			OFF_CTRL:   regs[0] = d & 32'h7fff;
			OFF_THRESH: regs[1] = d & 32'hfffff;
			OFF_SLEEP:  regs[2] = (d < 3) ? 32'd3 : (d > 134152192) ? 32'd134152192 : d;
			OFF_RXTIME: regs[3] = d & 32'h7ffffff;
			OFF_SYMBOL: regs[4] = (d[15:0] == 16'h0) ? regs[4] : d & 32'hffff;
			default:    ;
		endcase
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		check(32'(err), 32'(a > OFF_CAL));
	endtask : reg_read

	task automatic reg_check(input logic [7:0] a);
		reg_read(a);
		check(rd, (a > OFF_CAL) ? 32'h0 : regs[a >> 2]);
	endtask : reg_check

	task automatic stop_test;
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	// Bound reckoned from the longest run of the sequence below
	initial
	begin
		repeat (30000) @(posedge clk);
		num_errors++;
		stop_test;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		seed = 32'hc928;
		regs = '{32'h507c, 32'h3cff7, 32'h3, 32'h7d0, 32'h1964};
		rst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		level = 8'hc8;
		fsk_tone = 1'b0;
		num_errors = 0;
		n_compared = 0;
		repeat (12) @(posedge clk);
		check({afc_en, agc_en, trim, sar_dac, demod_data}, {2'b11, 6'h20, 8'h80, 1'b0});
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 5; i++)
			reg_check(8'(i * 4));
		reg_check(8'h1c);
		reg_write(OFF_STATUS, 32'hffffffff);
		reg_write(8'h20, 32'h1);
		reg_write(OFF_CTRL, 32'h1064);
		@(posedge clk);
		check({afc_en, agc_en}, 2'b00);
		reg_write(OFF_CTRL, 32'h107c);
		reg_write(OFF_SYMBOL, 32'h0);
		reg_write(OFF_SYMBOL, 32'h10);
		for (int i = 0; i < 3; i++)
		begin
			reg_write(OFF_SLEEP, i == 0 ? 32'h0 : i == 1 ? 32'h7ffffff : 32'd134152192);
			reg_check(OFF_SLEEP);
		end
		for (int n = 0; n < 400 && rx_active !== 1'b1; n++)
		begin
			@(posedge clk);
			check(32'(demod_data & ~rx_active), 32'h0);
		end
		check(rx_active, 1'b1);
		check(trim, 6'h1f);
		level <= 8'd30;
		repeat (60) @(posedge clk);
		level <= 8'd51;
		repeat (40) @(posedge clk);
		check(demod_enable, 1'b0);
		level <= 8'd52;
		for (int n = 0; n < 60 && demod_enable !== 1'b1; n++)
			@(posedge clk);
		check(demod_enable, 1'b1);
		fsk_tone <= 1'b1;
		repeat (40) @(posedge clk);
		check(demod_data, 1'b1);
		p0 = int'(sym_clk);
		repeat (16) @(posedge clk);
		check(sym_clk, !p0[0]);
		reg_write(OFF_CTRL, 32'h107e);
		repeat (40) @(posedge clk);
		check(demod_data, 1'b0);
		for (int m = 0; m < 2; m++)
		begin
			reg_write(OFF_CTRL, m == 0 ? 32'h107c : 32'h1078);
			fsk_tone <= 1'b0;
			repeat (128) @(posedge clk);
			for (int k = 0; k < 20; k++)
			begin
				fsk_tone <= k[0];
				repeat (32) @(posedge clk);
				if (k == 11 && m == 0)
					check(preamble_valid, 1'b0);
			end
			check(preamble_valid, 1'b1);
		end
		reg_write(OFF_THRESH, 32'h3c0a7);
		level <= 8'd42;
		repeat (40) @(posedge clk);
		check(demod_enable, 1'b1);
		level <= 8'd41;
		for (int n = 0; n < 60 && demod_enable !== 1'b0; n++)
			@(posedge clk);
		repeat (40) @(posedge clk);
		check({demod_enable, demod_data}, 2'b00);
		reg_write(OFF_CTRL, 32'h105d);
		level <= 8'd61;
		repeat (48) @(posedge clk);
		check(demod_data, 1'b1);
		level <= 8'd60;
		repeat (48) @(posedge clk);
		check(demod_data, 1'b0);
		reg_write(OFF_CTRL, 32'h107d);
		level <= 8'd250;
		repeat (30) @(posedge clk);
		level <= 8'd130;
		repeat (48) @(posedge clk);
		check(demod_data, 1'b1);
		level <= 8'd120;
		repeat (48) @(posedge clk);
		check(demod_data, 1'b0);
		for (int i = 0; i < 9; i++)
		begin
			per = (i == 8) ? 40 : 128 >> (i % 4);
			reg_write(OFF_CTRL, (i == 8) ? 32'h103d : 32'h107d | 32'((i % 4) << 7) | 32'(i << 9));
			level <= 8'd250;
			repeat (30) @(posedge clk);
			level <= 8'd0;
			repeat (30) @(posedge clk);
			reg_read(OFF_STATUS);
			p0 = int'(rd[15:8]);
			repeat (8 * per) @(posedge clk);
			reg_read(OFF_STATUS);
			drop = p0 - int'(rd[15:8]);
			if (i == 8)
				check(32'(drop), 32'h0);
			else
				check(32'(drop >= 7 * steps[i] && drop <= 9 * steps[i]), 32'h1);
		end
		for (int i = 0; i < 4; i++)
		begin
			level <= 8'($random(seed));
			repeat (30) @(posedge clk);
			reg_read(OFF_STATUS);
			check(rd[7:0], level);
		end
		stop_test;
	end
endmodule : rssi_gated_demod_control_test
